// >>> rtl/dcc_pkg.sv
`default_nettype none
package dcc_pkg;
  // ---------------------------------------------------------------
  // register map (byte-wide registers on the serial host port)
  // ---------------------------------------------------------------
  localparam logic [7:0] DCC_ADDR_A_MODE = 8'h02;
  localparam logic [7:0] DCC_ADDR_A_LIMIT = 8'h03;
  localparam logic [7:0] DCC_ADDR_B_MODE = 8'h04;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DCC_BIT_ENABLE = 0;
  localparam int DCC_BIT_SRC_LO = 1;
  localparam int DCC_BIT_SRC_HI = 2;
  localparam int DCC_BIT_DISCHARGE = 3;
  localparam int DCC_BIT_FPWM = 4;
  localparam int DCC_BIT_MULTIPHASE = 5;
  localparam int DCC_BIT_SLEW_LO = 0;
  localparam int DCC_BIT_SLEW_HI = 2;
  localparam int DCC_BIT_ILIM_LO = 3;
  localparam int DCC_BIT_ILIM_HI = 5;
  // ---------------------------------------------------------------
  // writable masks and fixed reset parts
  // ---------------------------------------------------------------
  localparam logic [7:0] DCC_MASK_A_MODE = 8'hff;
  localparam logic [7:0] DCC_MASK_B_MODE = 8'hff;
  localparam logic [7:0] DCC_MASK_LIMIT = 8'hff;
  localparam logic [7:0] DCC_DISCHARGE_RESET = 8'h08;
  localparam logic [7:0] DCC_LIMIT_RESET = 8'h1a;
  localparam logic [7:0] DCC_B_MODE_RESET = 8'h08;
  // ---------------------------------------------------------------
  // enable source codes and reserved codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DCC_SRC_BIT_ONLY = 2'b00,
    DCC_SRC_PIN_1 = 2'b01,
    DCC_SRC_PIN_2 = 2'b10,
    DCC_SRC_PIN_3 = 2'b11
  } dcc_src_type;
  localparam logic [2:0] DCC_ILIM_RESERVED = 3'h7;
  localparam logic [2:0] DCC_SLEW_FIRST_VALID = 3'h2;
endpackage
`default_nettype wire

// >>> rtl/dcc_regs.sv
`default_nettype none
module dcc_regs
  import dcc_pkg::*;
(
  input wire logic clk_sys, // register clock, 200 MHz
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] otp_a_mode, // one-time defaults for converter a mode register
  input wire logic [7:0] otp_a_limit, // one-time defaults for limit and slew
  input wire logic [7:0] otp_b_mode, // one-time defaults for converter b mode register
  input wire logic reg_write, // host write strobe, one cycle
  input wire logic reg_read, // host read strobe, one cycle
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, valid the cycle after the read
  input wire logic enable_pin_1, // external enable pin 1
  input wire logic enable_pin_2, // external enable pin 2
  input wire logic enable_pin_3, // external enable pin 3
  output logic converter_a_on, // effective enable of converter a
  output logic converter_b_on, // effective enable of converter b
  output logic conv_a_forced_pwm, // converter a forced pwm
  output logic conv_b_forced_pwm, // converter b forced pwm
  output logic conv_a_forced_multiphase, // converter a forced two-phase
  output logic conv_a_discharge_on, // converter a discharge resistor connected
  output logic conv_b_discharge_on, // converter b discharge resistor connected
  output logic [2:0] conv_a_peak_current_limit, // converter a limit code
  output logic [2:0] conv_a_ramp_rate // converter a slew code
);
  import dcc_pkg::*;

  logic [7:0] conv_a_mode_enable_ctrl;
  logic [7:0] conv_a_limit_slew_ctrl;
  logic [7:0] conv_b_mode_enable_ctrl;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic next_a_on;
  logic next_b_on;

  // pick the qualifying pin for a mode register
  function automatic logic dcc_qualified(input logic [7:0] mode, input logic [2:0] pins);
    logic gate;
    gate = 1'b1;
    case (dcc_src_type'(mode[DCC_BIT_SRC_HI:DCC_BIT_SRC_LO]))
      DCC_SRC_BIT_ONLY: gate = 1'b1;
      DCC_SRC_PIN_1: gate = pins[0];
      DCC_SRC_PIN_2: gate = pins[1];
      DCC_SRC_PIN_3: gate = pins[2];
      default: gate = 1'b0;
    endcase
    return mode[DCC_BIT_ENABLE] & gate;
  endfunction

  // ---------------------------------------------------------------
  // host writes
  // ---------------------------------------------------------------
  // defaults are reloaded from one-time memory at each reset; discharge default is constant
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conv_a_mode_enable_ctrl <= (otp_a_mode & ~DCC_DISCHARGE_RESET) | DCC_DISCHARGE_RESET;
    end else if (reg_write && reg_addr == DCC_ADDR_A_MODE) begin
      conv_a_mode_enable_ctrl <= reg_wdata & DCC_MASK_A_MODE;
    end
  end

  // limit takes effect on write with no need to stop the converter
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conv_a_limit_slew_ctrl <= otp_a_limit;
    end else if (reg_write && reg_addr == DCC_ADDR_A_LIMIT) begin
      conv_a_limit_slew_ctrl <= reg_wdata & DCC_MASK_LIMIT;
    end
  end

  // converter b mode register: same layout, spare bits 7-5 are kept so software reads back what it wrote
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conv_b_mode_enable_ctrl <= (otp_b_mode & ~DCC_DISCHARGE_RESET) | DCC_DISCHARGE_RESET;
    end else if (reg_write && reg_addr == DCC_ADDR_B_MODE) begin
      conv_b_mode_enable_ctrl <= reg_wdata & DCC_MASK_B_MODE;
    end
  end

  // ---------------------------------------------------------------
  // host reads
  // ---------------------------------------------------------------
  // unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        DCC_ADDR_A_MODE: reg_rdata <= conv_a_mode_enable_ctrl;
        DCC_ADDR_A_LIMIT: reg_rdata <= conv_a_limit_slew_ctrl;
        DCC_ADDR_B_MODE: reg_rdata <= conv_b_mode_enable_ctrl;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // enable pins
  // ---------------------------------------------------------------
  // two stages: pins are asynchronous in practice, so the first stage only feeds the second
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {enable_pin_3, enable_pin_2, enable_pin_1};
      pin_sync <= pin_meta;
    end
  end

  assign next_a_on = dcc_qualified(conv_a_mode_enable_ctrl, pin_sync);
  assign next_b_on = dcc_qualified(conv_b_mode_enable_ctrl, pin_sync);

  // ---------------------------------------------------------------
  // converter controls
  // ---------------------------------------------------------------
  // registered so the power stage never sees a decode glitch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      converter_a_on <= 1'b0;
      converter_b_on <= 1'b0;
      conv_a_discharge_on <= 1'b0;
      conv_b_discharge_on <= 1'b0;
    end else begin
      converter_a_on <= next_a_on;
      converter_b_on <= next_b_on;
      conv_a_discharge_on <= ~next_a_on & conv_a_mode_enable_ctrl[DCC_BIT_DISCHARGE];
      conv_b_discharge_on <= ~next_b_on & conv_b_mode_enable_ctrl[DCC_BIT_DISCHARGE];
    end
  end

  // mode, limit and slew codes pass on unchanged; reserved codes are the analog side's concern
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conv_a_forced_pwm <= 1'b0;
      conv_b_forced_pwm <= 1'b0;
      conv_a_forced_multiphase <= 1'b0;
      conv_a_peak_current_limit <= 3'h0;
      conv_a_ramp_rate <= 3'h0;
    end else begin
      conv_a_forced_pwm <= conv_a_mode_enable_ctrl[DCC_BIT_FPWM];
      conv_b_forced_pwm <= conv_b_mode_enable_ctrl[DCC_BIT_FPWM];
      conv_a_forced_multiphase <= conv_a_mode_enable_ctrl[DCC_BIT_MULTIPHASE];
      conv_a_peak_current_limit <= conv_a_limit_slew_ctrl[DCC_BIT_ILIM_HI:DCC_BIT_ILIM_LO];
      conv_a_ramp_rate <= conv_a_limit_slew_ctrl[DCC_BIT_SLEW_HI:DCC_BIT_SLEW_LO];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_limit_write;
    reg_write && reg_addr == DCC_ADDR_A_LIMIT;
  endsequence
  sequence s_b_mode_read;
    reg_read && reg_addr == DCC_ADDR_B_MODE;
  endsequence
  // both synchroniser stages have run free of reset for the last two edges
  sequence s_sync_clean;
    !$past(reset) && !$past(reset, 2);
  endsequence

  AST_FPWM_A: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) |-> conv_a_forced_pwm == $past(conv_a_mode_enable_ctrl[DCC_BIT_FPWM]))
    else $error("forced pwm a does not follow register");
  AST_FPWM_B: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) |-> conv_b_forced_pwm == $past(conv_b_mode_enable_ctrl[DCC_BIT_FPWM]))
    else $error("forced pwm b does not follow register");
  AST_DISCH_A: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) |-> conv_a_discharge_on == (!converter_a_on && $past(conv_a_mode_enable_ctrl[DCC_BIT_DISCHARGE])))
    else $error("discharge a wrong for enable state");
  AST_DISCH_B: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) |-> conv_b_discharge_on == (!converter_b_on && $past(conv_b_mode_enable_ctrl[DCC_BIT_DISCHARGE])))
    else $error("discharge b wrong for enable state");
  AST_SRC_A: assert property (@(posedge clk_sys) disable iff (reset)
    (conv_a_mode_enable_ctrl[DCC_BIT_SRC_HI:DCC_BIT_SRC_LO] == DCC_SRC_PIN_2 && !pin_sync[1]) |=> !converter_a_on)
    else $error("converter a on with its pin low");
  AST_EN_B: assert property (@(posedge clk_sys) disable iff (reset)
    !conv_b_mode_enable_ctrl[DCC_BIT_ENABLE] |=> !converter_b_on)
    else $error("converter b on with enable bit clear");
  AST_EN_A: assert property (@(posedge clk_sys) disable iff (reset)
    !conv_a_mode_enable_ctrl[DCC_BIT_ENABLE] |=> !converter_a_on)
    else $error("converter a on with enable bit clear");
  AST_SRC_B: assert property (@(posedge clk_sys) disable iff (reset)
    (conv_b_mode_enable_ctrl[DCC_BIT_SRC_HI:DCC_BIT_SRC_LO] == DCC_SRC_BIT_ONLY &&
     conv_b_mode_enable_ctrl[DCC_BIT_ENABLE]) |=> converter_b_on)
    else $error("converter b off although bit alone enables it");
  AST_READ_B: assert property (@(posedge clk_sys) disable iff (reset)
    s_b_mode_read |=> reg_rdata == $past(conv_b_mode_enable_ctrl))
    else $error("read of b mode register returned wrong value");
  AST_ILIM: assert property (@(posedge clk_sys) disable iff (reset)
    s_limit_write |=> ##1 conv_a_peak_current_limit == $past(reg_wdata[DCC_BIT_ILIM_HI:DCC_BIT_ILIM_LO], 2))
    else $error("limit code not applied two cycles after write");
  AST_SLEW: assert property (@(posedge clk_sys) disable iff (reset)
    s_limit_write |=> ##1 conv_a_ramp_rate == $past(reg_wdata[DCC_BIT_SLEW_HI:DCC_BIT_SLEW_LO], 2))
    else $error("slew code not applied two cycles after write");
  AST_MULTI: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(reset) |-> conv_a_forced_multiphase == $past(conv_a_mode_enable_ctrl[DCC_BIT_MULTIPHASE]))
    else $error("multiphase output does not follow register");
  AST_RESET_B: assert property (@(posedge clk_sys)
    $fell(reset) |-> conv_b_mode_enable_ctrl[DCC_BIT_DISCHARGE])
    else $error("discharge default lost after reset");
  AST_SYNC: assert property (@(posedge clk_sys) disable iff (reset)
    s_sync_clean |-> pin_sync[0] == $past(enable_pin_1, 2))
    else $error("pin synchroniser delay wrong");
  AST_SYNC_2: assert property (@(posedge clk_sys) disable iff (reset)
    s_sync_clean |-> pin_sync[1] == $past(enable_pin_2, 2))
    else $error("pin 2 synchroniser delay wrong");
  AST_SYNC_3: assert property (@(posedge clk_sys) disable iff (reset)
    s_sync_clean |-> pin_sync[2] == $past(enable_pin_3, 2))
    else $error("pin 3 synchroniser delay wrong");
  AST_RESET_A: assert property (@(posedge clk_sys)
    $fell(reset) |-> conv_a_mode_enable_ctrl[DCC_BIT_DISCHARGE])
    else $error("discharge default of a lost after reset");
  AST_LIMIT_RESET: assert property (@(posedge clk_sys)
    $fell(reset) |-> conv_a_limit_slew_ctrl == $past(otp_a_limit))
    else $error("limit register not loaded from one-time defaults");
endmodule
`default_nettype wire

// >>> verification/dcc_regs_tb_top.sv
`default_nettype none
module dcc_regs_tb_top
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // stimulus, model state and design
  // ---------------------------------------------------------------
  logic clk_sys, reset, reg_write, reg_read;
  logic [7:0] otp_a_mode, otp_a_limit, otp_b_mode, reg_addr, reg_wdata, reg_rdata;
  logic [2:0] pins, ilim, ramp;
  logic on_a, on_b, fpwm_a, fpwm_b, mp_a, dis_a, dis_b;
  logic [7:0] m_a, m_l, m_b, addr_tab [4];
  int failures, n_tests;
  always #2.5 clk_sys = ~clk_sys; // 200 MHz
  dcc_regs DUT (.clk_sys(clk_sys), .reset(reset), .otp_a_mode(otp_a_mode), .otp_a_limit(otp_a_limit),
    .otp_b_mode(otp_b_mode), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enable_pin_1(pins[0]), .enable_pin_2(pins[1]),
    .enable_pin_3(pins[2]), .converter_a_on(on_a), .converter_b_on(on_b), .conv_a_forced_pwm(fpwm_a),
    .conv_b_forced_pwm(fpwm_b), .conv_a_forced_multiphase(mp_a), .conv_a_discharge_on(dis_a),
    .conv_b_discharge_on(dis_b), .conv_a_peak_current_limit(ilim), .conv_a_ramp_rate(ramp));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // model of the effective enable: source 0 means the bit alone
  function automatic logic exp_on(input logic [7:0] r);
    logic [1:0] src;
    src = r[2:1];
    return r[0] & ((src == 2'b00) ? 1'b1 : pins[src - 2'd1]);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    n_tests++;
    if (got !== want) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // the read is taken at the second edge and answered in the same update
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, want, "read back");
  endtask
  // outputs compared against the model once the pin synchroniser has settled
  task automatic check_all();
    repeat (4) @(posedge clk_sys);
    #1;
    chk({7'h00, on_a}, {7'h00, exp_on(m_a)}, "a on");
    chk({7'h00, on_b}, {7'h00, exp_on(m_b)}, "b on");
    chk({7'h00, fpwm_a}, {7'h00, m_a[4]}, "a fpwm");
    chk({7'h00, fpwm_b}, {7'h00, m_b[4]}, "b fpwm");
    chk({7'h00, mp_a}, {7'h00, m_a[5]}, "a multiphase");
    chk({7'h00, dis_a}, {7'h00, m_a[3] & ~exp_on(m_a)}, "a discharge");
    chk({7'h00, dis_b}, {7'h00, m_b[3] & ~exp_on(m_b)}, "b discharge");
    chk({5'h00, ilim}, {5'h00, m_l[5:3]}, "limit code");
    chk({5'h00, ramp}, {5'h00, m_l[2:0]}, "ramp code");
    rd(DCC_ADDR_A_MODE, m_a);
    rd(DCC_ADDR_A_LIMIT, m_l);
    rd(DCC_ADDR_B_MODE, m_b);
    rd(8'h07, 8'h00); // unmapped offset reads zero
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] a, d;
    void'($urandom(32'hd0ce));
    addr_tab = '{DCC_ADDR_A_MODE, DCC_ADDR_A_LIMIT, DCC_ADDR_B_MODE, 8'h07};
    clk_sys = 1'b0;
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pins = 3'h0;
    failures = 0;
    n_tests = 0;
    // random one-time defaults for a; limit and b keep the documented factory values
    otp_a_mode = 8'($urandom);
    otp_a_limit = 8'h1a;
    otp_b_mode = 8'h00;
    m_a = otp_a_mode | 8'h08;
    m_l = 8'h1a;
    m_b = 8'h08;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    check_all();
    // random writes, unmapped ones included, with the enable pins moving underneath
    for (int i = 0; i < 80; i++) begin
      // second reset halfway, with fresh one-time defaults in all three registers
      if (i == 40) begin
        m_a = 8'($urandom);
        m_l = 8'($urandom);
        m_b = 8'($urandom);
        @(posedge clk_sys);
        reset <= 1'b1;
        otp_a_mode <= m_a;
        otp_a_limit <= m_l;
        otp_b_mode <= m_b;
        m_a = m_a | 8'h08;
        m_b = m_b | 8'h08;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        check_all();
      end
      a = addr_tab[$urandom % 4];
      d = 8'($urandom);
      @(posedge clk_sys);
      pins <= 3'($urandom);
      wr(a, d);
      if (a == DCC_ADDR_A_MODE) m_a = d;
      if (a == DCC_ADDR_A_LIMIT) m_l = d;
      if (a == DCC_ADDR_B_MODE) m_b = d;
      check_all();
    end
    close_out();
  end
  // no run may hang: an exhausted bound counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
